// ### common/bscc_pkg.sv
// package for the bit-skip / call / clear execution slice of an 8-bit core
// assumes one instruction-cycle clock and a fetch path that supplies one word per cycle
//
// Overview of operation
// - skip next word when tested bit is one
// - taken skip flushes prefetch, two cycles
// - skip-if-set decoded from 0111 bbb fffffff
// - call pushes own pc plus one
// - call immediate loads pc bits ten..zero
// - call upper pc bits from high latch
// - latch bits four..three into pc twelve..eleven
// - call is one word, two cycles
// - clear file register writes zero, sets zero
// - clear work register writes zero, sets zero
package bscc_pkg;

  localparam int unsigned IW = 14;
  localparam int unsigned PW = 13;

  // opcode patterns and masks
  localparam logic [13:0] OP_SKIP_SET_MASK = 14'h3c00;
  localparam logic [13:0] OP_SKIP_SET_VAL  = 14'h1c00;
  localparam logic [13:0] OP_CALL_MASK     = 14'h3800;
  localparam logic [13:0] OP_CALL_VAL      = 14'h2000;
  localparam logic [13:0] OP_CLR_FILE_MASK = 14'h3f80;
  localparam logic [13:0] OP_CLR_FILE_VAL  = 14'h0180;
  localparam logic [13:0] OP_CLR_WORK_VAL  = 14'h0103;

  // field positions
  localparam int unsigned BIT_IDX_LSB  = 7;
  localparam int unsigned FILE_ADR_LSB = 0;
  localparam int unsigned LATCH_LSB    = 3;

  // reset values
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0]  W_RESET  = 8'h00;

  typedef enum logic [0:0] {
    BSCC_EXEC  = 1'b0,
    BSCC_FLUSH = 1'b1
  } bscc_phase_e;

  // register-file write request
  typedef struct packed {
    logic       en;
    logic [6:0] adr;
    logic [7:0] data;
  } bscc_fwr_s;

  // stack push request
  typedef struct packed {
    logic        en;
    logic [12:0] adr;
  } bscc_push_s;

  typedef struct packed {
    bscc_phase_e phase;
    logic [12:0] pc;
    logic [7:0]  work;
    logic        zero;
    bscc_fwr_s   fwr;
    bscc_push_s  push;
    logic        skip_taken;
  } bscc_state_s;

endpackage

// ### hdl/bscc_decode.sv
// instruction classifier for the four supported instructions
// assumes a stable 14-bit word on its input in the same cycle
`timescale 1ns/1ps
module bscc_decode
  import bscc_pkg::*;
(
  // instruction word
  input  wire logic [13:0] i_word,
  // class flags
  output logic             o_is_skip,
  output logic             o_is_call,
  output logic             o_is_clr_file,
  output logic             o_is_clr_work
);
  // pure pattern matching, no state
  always_comb begin
    o_is_skip = (i_word & OP_SKIP_SET_MASK) == OP_SKIP_SET_VAL;
    o_is_call = (i_word & OP_CALL_MASK) == OP_CALL_VAL;
    o_is_clr_file = (i_word & OP_CLR_FILE_MASK) == OP_CLR_FILE_VAL;
    o_is_clr_work = i_word == OP_CLR_WORK_VAL;
  end
endmodule

// ### hdl/bscc_exec.sv
// execution unit for skip-if-set, call, clear file and clear work instructions
// a call parks pc on its target for two cycles; only the second copy executes
// assumes the fetch path presents the word at o_pc each cycle and
// that file-register read data for i_word's address arrives combinationally
`timescale 1ns/1ps
module bscc_exec
  import bscc_pkg::*;
(
  // clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset_n,
  // fetch path
  input  wire logic [13:0]          i_word,
  input  wire logic [4:0]           i_pc_high_latch,
  // file register read port
  input  wire logic [7:0]           i_file_rd,
  output logic [6:0]                o_file_rd_adr,
  // results
  output logic [12:0]               o_pc,
  output logic [7:0]                o_work,
  output logic                      o_zero,
  output bscc_pkg::bscc_fwr_s       o_file_wr,
  output bscc_pkg::bscc_push_s      o_push,
  output logic                      o_flush
);
  import bscc_pkg::*;

  bscc_state_s st;
  bscc_state_s next_st;
  logic        is_skip;
  logic        is_call;
  logic        is_clr_file;
  logic        is_clr_work;
  logic [2:0]  bit_idx;

  bscc_decode i_bscc_decode (
    .i_word        (i_word),
    .o_is_skip     (is_skip),
    .o_is_call     (is_call),
    .o_is_clr_file (is_clr_file),
    .o_is_clr_work (is_clr_work)
  );

  assign bit_idx       = i_word[BIT_IDX_LSB +: 3];
  assign o_file_rd_adr = i_word[FILE_ADR_LSB +: 7];

  //////////////////////////////////////////////////////////////////////
  // next state: one word executes per cycle, flush phase swallows one
  always_comb begin
    next_st            = st;
    next_st.fwr        = '0;
    next_st.push       = '0;
    next_st.skip_taken = 1'b0;
    next_st.phase      = BSCC_EXEC;
    case (st.phase)
      BSCC_FLUSH: begin
        // discarded word runs as a no-op; a skip steps past it, while a
        // call holds pc so the target word is fetched again and executed
        if (st.skip_taken) begin
          next_st.pc = st.pc + 13'h0001;
        end else begin
          next_st.pc = st.pc;
        end
      end
      BSCC_EXEC: begin
        next_st.pc = st.pc + 13'h0001;
        if (is_skip) begin
          if (i_file_rd[bit_idx]) begin
            next_st.phase      = BSCC_FLUSH;
            next_st.skip_taken = 1'b1;
          end
        end else if (is_call) begin
          next_st.push.en  = 1'b1;
          next_st.push.adr = st.pc + 13'h0001;
          // upper bits from the latch, never from the word
          next_st.pc = {i_pc_high_latch[LATCH_LSB +: 2], i_word[10:0]};
          next_st.phase = BSCC_FLUSH;
        end else if (is_clr_file) begin
          next_st.fwr.en   = 1'b1;
          next_st.fwr.adr  = i_word[FILE_ADR_LSB +: 7];
          next_st.fwr.data = 8'h00;
          next_st.zero     = 1'b1;
        end else if (is_clr_work) begin
          next_st.work = 8'h00;
          next_st.zero = 1'b1;
        end
      end
      default: next_st.phase = BSCC_EXEC;
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      st       <= '0;
      st.pc    <= PC_RESET;
      st.work  <= W_RESET;
      st.phase <= BSCC_EXEC;
    end else begin
      st <= next_st;
    end
  end

  assign o_pc      = st.pc;
  assign o_work    = st.work;
  assign o_zero    = st.zero;
  assign o_file_wr = st.fwr;
  assign o_push    = st.push;
  assign o_flush   = st.phase == BSCC_FLUSH;

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_call_issue;
    st.phase == BSCC_EXEC && is_call;
  endsequence

  sequence s_flush_then_exec;
    o_flush ##1 !o_flush;
  endsequence

  // skip outcomes, judged on the bit read in the issuing cycle
  sequence s_skip_set;
    st.phase == BSCC_EXEC && is_skip && i_file_rd[bit_idx];
  endsequence

  sequence s_skip_clear;
    st.phase == BSCC_EXEC && is_skip && !i_file_rd[bit_idx];
  endsequence

  // clear instructions entering execution
  sequence s_clr_file_issue;
    st.phase == BSCC_EXEC && is_clr_file;
  endsequence

  sequence s_clr_work_issue;
    st.phase == BSCC_EXEC && is_clr_work;
  endsequence

  // the two kinds of discard cycle, told apart by the skip marker
  sequence s_skip_flush;
    o_flush && st.skip_taken;
  endsequence

  sequence s_call_flush;
    o_flush && !st.skip_taken;
  endsequence

  a_skip_when_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (st.phase == BSCC_EXEC && is_skip && i_file_rd[bit_idx]) |=> o_flush)
    else $error("skip with bit set did not flush");
  a_no_skip_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (st.phase == BSCC_EXEC && is_skip && !i_file_rd[bit_idx]) |=> !o_flush)
    else $error("skip taken with bit clear");
  a_skip_two_cyc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (st.phase == BSCC_EXEC && is_skip && i_file_rd[bit_idx]) |=> s_flush_then_exec)
    else $error("taken skip not two cycles");
  a_decode_skip: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    is_skip |-> i_word[13:10] == 4'h7)
    else $error("skip decode wrong");

  // return address and both halves of the call target
  a_call_push: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_call_issue |=> o_push.en && o_push.adr == $past(st.pc) + 13'h0001)
    else $error("call push address wrong");
  a_call_low_pc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_call_issue |=> o_pc[10:0] == $past(i_word[10:0]))
    else $error("call low pc wrong");
  a_call_high_pc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_call_issue |=> o_pc[12:11] == $past(i_pc_high_latch[4:3]))
    else $error("call high pc not from latch");
  a_call_two_cyc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_call_issue |=> s_flush_then_exec)
    else $error("call not two cycles");
  a_call_flush: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_call_issue |=> o_flush && !o_file_wr.en)
    else $error("call did not flush prefetch");

  // clear results land one cycle after issue
  a_clr_file_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_clr_file_issue |=> o_file_wr.en && o_file_wr.data == 8'h00 && o_zero)
    else $error("clear file failed");
  a_clr_work_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_clr_work_issue |=> o_work == 8'h00 && o_zero)
    else $error("clear work failed");

  // pc around a skip; a taken skip must land past the dropped word
  a_skip_set_pc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_skip_set |=> o_pc == $past(o_pc) + 13'h0001)
    else $error("taken skip did not step to the next word");
  a_skip_clear_pc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_skip_clear |=> o_pc == $past(o_pc) + 13'h0001)
    else $error("untaken skip did not step to the next word");
  a_skip_past_word: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_skip_flush |=> o_pc == $past(o_pc) + 13'h0001 && !o_flush)
    else $error("taken skip did not pass the dropped word");
  a_skip_no_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (st.phase == BSCC_EXEC && is_skip) |=> !o_file_wr.en && !o_push.en && o_zero == $past(o_zero))
    else $error("skip touched registers or flags");

  // the discard cycle must be a true no-op
  a_flush_no_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_flush |=> !o_file_wr.en && !o_push.en)
    else $error("discarded word wrote a register");
  a_flush_keeps_flags: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_flush |=> o_work == $past(o_work) && o_zero == $past(o_zero))
    else $error("discarded word changed work or zero");

  // call: the target word must not be lost to the flush
  a_call_resume: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_call_flush |=> o_pc == $past(o_pc) && !o_flush)
    else $error("call flush did not resume at target");
  a_call_one_push: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_call_issue |-> ##2 !o_push.en)
    else $error("call pushed more than once");

  // clears finish in their own cycle
  a_clr_file_adr: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_clr_file_issue |=> o_file_wr.adr == $past(o_file_rd_adr))
    else $error("clear file hit the wrong address");
  a_clr_file_cyc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_clr_file_issue |=> !o_flush)
    else $error("clear file took more than one cycle");
  a_clr_work_cyc: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_clr_work_issue |=> !o_flush && !o_file_wr.en)
    else $error("clear work took more than one cycle");
endmodule

// ### tb/bscc_prog_mem.sv
// program memory model for the execution slice
// assumes the core reads the word at its pc within the same cycle
`timescale 1ns/1ps
module bscc_prog_mem
  import bscc_pkg::*;
(
  // fetch address and word
  input  wire logic [12:0] i_pc,
  output logic [13:0]      o_word
);
  logic [13:0] mem [0:8191];
  // empty words read as no-op, never unknown
  initial begin
    foreach (mem[k]) mem[k] = 14'h0000;
  end
  assign o_word = mem[i_pc];
endmodule

// ### tb/test_bit_skip_call_clear_exec.sv
// self-checking bench for the execution slice
// assumes the program memory model and a file register array kept here
`timescale 1ns/1ps
module test_bit_skip_call_clear_exec;
  import bscc_pkg::*;
  typedef struct packed {
    logic [4:0]  latch;
    logic [12:0] pc;
    logic        flush;
    logic        push;
    logic [12:0] padr;
    logic        fwr;
    logic [6:0]  fadr;
  } bscc_row_s;
  logic        i_mclk, i_reset_n, zero, flush;
  logic [4:0]  latch;
  logic [7:0]  fregs [128];
  logic [7:0]  work;
  logic [13:0] word;
  logic [6:0]  rd_adr;
  logic [12:0] pc;
  bscc_fwr_s   fwr;
  bscc_push_s  push;
  int          error_cnt, checks_done, cyc;
  // one row per executed cycle, expected state after its edge
  bscc_row_s   rows [12] = '{
    '{5'h00, 13'h0001, 1'b0, 1'b0, 13'h0000, 1'b0, 7'h00}, '{5'h00, 13'h0002, 1'b1, 1'b0, 13'h0000, 1'b0, 7'h00},
    '{5'h00, 13'h0003, 1'b0, 1'b0, 13'h0000, 1'b0, 7'h00}, '{5'h00, 13'h0004, 1'b0, 1'b0, 13'h0000, 1'b0, 7'h00},
    '{5'h00, 13'h0005, 1'b0, 1'b0, 13'h0000, 1'b1, 7'h7f}, '{5'h0f, 13'h0923, 1'b1, 1'b1, 13'h0006, 1'b0, 7'h00},
    '{5'h00, 13'h0923, 1'b0, 1'b0, 13'h0000, 1'b0, 7'h00}, '{5'h00, 13'h0924, 1'b0, 1'b0, 13'h0000, 1'b1, 7'h10},
    '{5'h18, 13'h1fff, 1'b1, 1'b1, 13'h0925, 1'b0, 7'h00}, '{5'h00, 13'h1fff, 1'b0, 1'b0, 13'h0000, 1'b0, 7'h00},
    '{5'h00, 13'h0000, 1'b0, 1'b0, 13'h0000, 1'b0, 7'h00}, '{5'h00, 13'h0001, 1'b0, 1'b0, 13'h0000, 1'b0, 7'h00}};

  bscc_prog_mem i_bscc_prog_mem (.i_pc(pc), .o_word(word));
  bscc_exec i_bscc_exec (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_word(word), .i_pc_high_latch(latch),
    .i_file_rd(fregs[rd_adr]), .o_file_rd_adr(rd_adr), .o_pc(pc), .o_work(work), .o_zero(zero),
    .o_file_wr(fwr), .o_push(push), .o_flush(flush));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // file registers take the core's write strobe
  always @(posedge i_mclk) begin
    if (fwr.en) fregs[fwr.adr] <= fwr.data;
  end
  // hang guard, far above the ~20 cycles needed
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 200) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset_n = 1'b0;
    latch = 5'h00;
    foreach (fregs[k]) fregs[k] = 8'h00;
    fregs[5] = 8'h80;
    fregs[127] = 8'h5a;
    fregs[16] = 8'h33;
    // load after the model clears its memory at time zero
    #1;
    i_bscc_prog_mem.mem[0] = 14'h0103;
    i_bscc_prog_mem.mem[1] = 14'h1f85;
    i_bscc_prog_mem.mem[2] = 14'h0185;
    i_bscc_prog_mem.mem[3] = 14'h1c06;
    i_bscc_prog_mem.mem[4] = 14'h01ff;
    i_bscc_prog_mem.mem[5] = 14'h2123;
    i_bscc_prog_mem.mem[13'h0923] = 14'h0190;
    i_bscc_prog_mem.mem[13'h0924] = 14'h27ff;
    repeat (3) @(posedge i_mclk);
    #1;
    chk("zero_rst", zero, 1'b0);
    i_reset_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      latch = rows[i].latch;
      @(posedge i_mclk);
      #1;
      chk("pc", pc, rows[i].pc);
      chk("flush", flush, rows[i].flush);
      chk("push_en", push.en, rows[i].push);
      if (rows[i].push) chk("push_adr", push.adr, rows[i].padr);
      chk("fwr_en", fwr.en, rows[i].fwr);
      if (rows[i].fwr) chk("fwr", {1'b0, fwr.adr, fwr.data}, {1'b0, rows[i].fadr, 8'h00});
      chk("zero", zero, 1'b1);
      chk("work", work, 8'h00);
    end
    chk("skipped", fregs[5], 8'h80);
    chk("cleared", fregs[127], 8'h00);
    chk("target_ran", fregs[16], 8'h00);
    // reset in mid-run returns the core to its start state
    i_reset_n = 1'b0;
    @(posedge i_mclk);
    #1;
    chk("pc_rst", pc, 13'h0000);
    chk("zero_rst2", zero, 1'b0);
    // first word after release clears a file register and sets zero
    i_bscc_prog_mem.mem[0] = 14'h0190;
    fregs[16] = 8'h33;
    i_reset_n = 1'b1;
    @(posedge i_mclk);
    #1;
    chk("fwr_rst", {fwr.en, fwr.adr, fwr.data}, {1'b1, 7'h10, 8'h00});
    chk("zero_clear_file_reg", zero, 1'b1);
    @(posedge i_mclk);
    #1;
    chk("cleared2", fregs[16], 8'h00);
    final_report();
  end
endmodule
